/* File: design/ccp_defines.vh */
// constants for the capture/compare/pwm control block
// Notes on behaviour
// - 8-bit control: mode bits 3-0, duty low bits 5-4, steering bits 7-6, reset zero.
// - mode 0000 turns the peripheral off and clears the compare latch, prescaler and pwm state; capture value and flag are kept.
// - mode 0010 toggles compare output and sets flag on each match.
// - modes 0100-0111 capture on falling, rising, every 4th, every 16th rising edge.
// - mode 1000 sets output on match, 1001 clears it; flag set in both.
// - mode 1010 sets flag on match and leaves the output pin alone.
// - mode 1011 sets flag on match and emits a timer-resetting special event.
// - modes 11xx are pwm; bit 1 inverts outputs a and c, bit 0 b and d.
// - outside pwm, output a is the capture/compare pin; b, c, d stay port pins.
// - steering: 00 single, 01 full forward, 10 half bridge, 11 full reverse.
// - pwm duty is capture low byte over the two duty low bits; unused otherwise.
// - capture and compare use time base one; pwm uses time base two.
// - each qualifying capture copies the full 16-bit time base one count.
// - capture sets the event flag; only software clears it.
// - a new capture overwrites an unread held value.
// - edges are detected even when the capture pin is driven as output.
// - prescaler counter clears when off, outside capture, and on reset.
// - writing zero forces the compare output latch low.
// - special event also starts a conversion when the converter is enabled.
`ifndef CCP_DEFINES_VH
`define CCP_DEFINES_VH
`define ADDR_MODE_CTRL 12'h000
`define ADDR_CAPT_LOW 12'h004
`define ADDR_CAPT_HIGH 12'h008
`define ADDR_STATUS 12'h00c
`define ADDR_PWM_PERIOD 12'h010
`define MODE_OFF 4'h0
`define MODE_CMP_TOGGLE 4'h2
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLEAR 4'h9
`define MODE_CMP_SOFT 4'ha
`define MODE_CMP_SPECIAL 4'hb
`define MODE_LSB 0
`define MODE_MSB 3
`define DUTY_LSB 4
`define DUTY_MSB 5
`define STEER_LSB 6
`define STEER_MSB 7
`define CTRL_RESET 8'h00
`define PERIOD_RESET 8'hff
`define STEER_SINGLE 2'h0
`define STEER_FULL_FWD 2'h1
`define STEER_HALF 2'h2
`define STEER_FULL_REV 2'h3
`define PRESCALE_4 4'h3
`define PRESCALE_16 4'hf
`endif

/* File: design/pin_sync.v */
// two-flop synchroniser for the capture pin
`timescale 1ns/10ps
module pin_sync (
  input wire ref_clk,
  input wire rst_b,
  input wire pinIn,
  output reg pinSync
);
  reg meta_r;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      pinSync <= 1'b0;
    end else begin
      meta_r <= pinIn;
      pinSync <= meta_r;
    end
  end
endmodule // pin_sync

/* File: design/capture_edge.v */
// edge detect and prescaler for capture events
`timescale 1ns/10ps
`include "ccp_defines.vh"
module capture_edge (
  input wire ref_clk,
  input wire rst_b,
  input wire pinSync,
  input wire [3:0] mode,
  output reg captureEvt
);
  reg prev_r;
  reg [3:0] presc_r;
  wire isCap = (mode[3:2] == 2'b01);
  wire rise = pinSync & ~prev_r;
  wire fall = ~pinSync & prev_r;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= 1'b0;
      presc_r <= 4'h0;
      captureEvt <= 1'b0;
    end else begin
      prev_r <= pinSync;
      captureEvt <= 1'b0;
      if (!isCap) begin
        presc_r <= 4'h0;
      end else begin
        case (mode)
          `MODE_CAP_FALL: captureEvt <= fall;
          `MODE_CAP_RISE: captureEvt <= rise;
          `MODE_CAP_RISE4: begin
            if (rise) begin
              presc_r <= (presc_r[1:0] == 2'h3) ? 4'h0 : presc_r + 4'h1;
              captureEvt <= (presc_r[1:0] == 2'h3);
            end
          end
          `MODE_CAP_RISE16: begin
            if (rise) begin
              presc_r <= presc_r + 4'h1;
              captureEvt <= (presc_r == `PRESCALE_16);
            end
          end
          default: captureEvt <= 1'b0;
        endcase
      end
    end
  end
endmodule // capture_edge

/* File: design/capture_compare_pwm_control.v */
// capture/compare/pwm mode control with apb register access
`timescale 1ns/10ps
`include "ccp_defines.vh"
module capture_compare_pwm_control (
  input wire ref_clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] timeBaseOne,
  input wire [7:0] timeBaseTwo,
  input wire converterEnabled,
  input wire capturePin,
  output reg outputA,
  output reg outputB,
  output reg outputC,
  output reg outputD,
  output reg outputAEn,
  output reg outputBEn,
  output reg outputCEn,
  output reg outputDEn,
  output reg ccpEventFlag,
  output reg specialEvent,
  output reg conversionStart
);
  reg [7:0] ctrl_r;
  reg [15:0] capt_r;
  reg [7:0] period_r;
  reg cmpLatch_r;
  reg [9:0] pwmCnt_r;
  reg pwmLevel_r;
  reg matchPrev_r;
  wire pinSync;
  wire captureEvt;
  wire [3:0] mode = ctrl_r[`MODE_MSB:`MODE_LSB];
  wire [1:0] duty = ctrl_r[`DUTY_MSB:`DUTY_LSB];
  wire [1:0] steer = ctrl_r[`STEER_MSB:`STEER_LSB];
  wire isPwm = (mode[3:2] == 2'b11);
  wire isCmp = (mode == `MODE_CMP_TOGGLE) || (mode[3:2] == 2'b10);
  // compare against time base one; act once per match, not every cycle it lasts
  wire matchNow = isCmp && (timeBaseOne == capt_r);
  wire matchEvt = matchNow && !matchPrev_r;
  wire apbAccess = psel && penable;
  wire apbWrite = apbAccess && pwrite;
  wire flagClr = apbWrite && (paddr == `ADDR_STATUS) && pwdata[0];
  wire [9:0] dutyVal = {capt_r[7:0], duty};
  wire [9:0] pwmTop = {period_r, 2'b11};
  wire modOut = pwmLevel_r;
  pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pinIn(capturePin),
    .pinSync(pinSync)
  );
  capture_edge u_edge (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pinSync(pinSync),
    .mode(mode),
    .captureEvt(captureEvt)
  );
  function legalAddr;
    input [11:0] a;
    begin
      legalAddr = (a == `ADDR_MODE_CTRL) || (a == `ADDR_CAPT_LOW) ||
                  (a == `ADDR_CAPT_HIGH) || (a == `ADDR_STATUS) ||
                  (a == `ADDR_PWM_PERIOD);
    end
  endfunction
  // apb: zero-wait slave, pready high in the access phase
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !legalAddr(paddr);
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `ADDR_MODE_CTRL: prdata <= {24'h000000, ctrl_r};
          `ADDR_CAPT_LOW: prdata <= {24'h000000, capt_r[7:0]};
          `ADDR_CAPT_HIGH: prdata <= {24'h000000, capt_r[15:8]};
          `ADDR_STATUS: prdata <= {31'h00000000, ccpEventFlag};
          `ADDR_PWM_PERIOD: prdata <= {24'h000000, period_r};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
  // registers; capture wins over a software write to the capture pair
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= `CTRL_RESET;
      capt_r <= 16'h0000;
      period_r <= `PERIOD_RESET;
      ccpEventFlag <= 1'b0;
      matchPrev_r <= 1'b0;
    end else begin
      matchPrev_r <= matchNow;
      if (apbWrite && pready && paddr == `ADDR_MODE_CTRL) ctrl_r <= pwdata[7:0];
      if (apbWrite && pready && paddr == `ADDR_PWM_PERIOD) period_r <= pwdata[7:0];
      if (captureEvt) begin
        capt_r <= timeBaseOne;
      end else if (apbWrite && pready && paddr == `ADDR_CAPT_LOW) begin
        capt_r[7:0] <= pwdata[7:0];
      end else if (apbWrite && pready && paddr == `ADDR_CAPT_HIGH) begin
        capt_r[15:8] <= pwdata[7:0];
      end
      // set wins over clear
      if (captureEvt || matchEvt) ccpEventFlag <= 1'b1;
      else if (flagClr && pready) ccpEventFlag <= 1'b0;
    end
  end
  // compare latch and special event
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmpLatch_r <= 1'b0;
      specialEvent <= 1'b0;
      conversionStart <= 1'b0;
    end else begin
      specialEvent <= matchEvt && (mode == `MODE_CMP_SPECIAL);
      conversionStart <= matchEvt && (mode == `MODE_CMP_SPECIAL) && converterEnabled;
      if (mode == `MODE_OFF) begin
        cmpLatch_r <= 1'b0;
      end else if (matchEvt) begin
        case (mode)
          `MODE_CMP_TOGGLE: cmpLatch_r <= ~cmpLatch_r;
          `MODE_CMP_SET: cmpLatch_r <= 1'b1;
          `MODE_CMP_CLEAR: cmpLatch_r <= 1'b0;
          default: cmpLatch_r <= cmpLatch_r;
        endcase
      end
    end
  end
  // pwm: 10-bit count, two fine bits plus time base two
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwmCnt_r <= 10'h000;
      pwmLevel_r <= 1'b0;
    end else if (!isPwm) begin
      pwmCnt_r <= 10'h000;
      pwmLevel_r <= 1'b0;
    end else begin
      pwmCnt_r <= (pwmCnt_r[9:2] >= period_r && pwmCnt_r[1:0] == 2'b11) ? 10'h000 :
                  {timeBaseTwo, pwmCnt_r[1:0] + 2'b01};
      pwmLevel_r <= (pwmCnt_r < dutyVal) && (pwmCnt_r <= pwmTop);
    end
  end
  // pin steering; pwm outputs are inverted per polarity bits
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      outputA <= 1'b0;
      outputB <= 1'b0;
      outputC <= 1'b0;
      outputD <= 1'b0;
      outputAEn <= 1'b0;
      outputBEn <= 1'b0;
      outputCEn <= 1'b0;
      outputDEn <= 1'b0;
    end else if (!isPwm) begin
      outputA <= cmpLatch_r;
      outputAEn <= (mode == `MODE_CMP_TOGGLE) || (mode == `MODE_CMP_SET) ||
                   (mode == `MODE_CMP_CLEAR);
      outputB <= 1'b0;
      outputC <= 1'b0;
      outputD <= 1'b0;
      outputBEn <= 1'b0;
      outputCEn <= 1'b0;
      outputDEn <= 1'b0;
    end else begin
      case (steer)
        `STEER_SINGLE: begin
          outputA <= modOut ^ mode[1];
          outputB <= 1'b0;
          outputC <= 1'b0;
          outputD <= 1'b0;
          {outputAEn, outputBEn, outputCEn, outputDEn} <= 4'h8;
        end
        `STEER_FULL_FWD: begin
          outputA <= 1'b1 ^ mode[1];
          outputB <= mode[0];
          outputC <= mode[1];
          outputD <= modOut ^ mode[0];
          {outputAEn, outputBEn, outputCEn, outputDEn} <= 4'hf;
        end
        `STEER_HALF: begin
          outputA <= modOut ^ mode[1];
          outputB <= ~modOut ^ mode[0];
          outputC <= 1'b0;
          outputD <= 1'b0;
          {outputAEn, outputBEn, outputCEn, outputDEn} <= 4'hc;
        end
        default: begin
          outputA <= mode[1];
          outputB <= modOut ^ mode[0];
          outputC <= 1'b1 ^ mode[1];
          outputD <= mode[0];
          {outputAEn, outputBEn, outputCEn, outputDEn} <= 4'hf;
        end
      endcase
    end
  end
endmodule // capture_compare_pwm_control

/* File: tb/capture_compare_pwm_control_chk.sv */
// port checker for the capture/compare/pwm control block
`timescale 1ns/10ps
module capture_compare_pwm_control_chk (
  input wire ref_clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire outputA,
  input wire outputAEn,
  input wire outputBEn,
  input wire outputCEn,
  input wire outputDEn,
  input wire ccpEventFlag,
  input wire specialEvent,
  input wire conversionStart
);
  reg [7:0] ctrl_r;
  reg [3:0] quiet_r;
  wire acc = psel && penable && pready && pwrite;
  // outputs lag a mode write by a few edges, so pin checks wait for quiet_r
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= 8'h00;
      quiet_r <= 4'h0;
    end else if (acc && paddr == 12'h000) begin
      ctrl_r <= pwdata[7:0];
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hf) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle");
  a_unmapped_err: assert property (pready && paddr > 12'h010 |-> pslverr)
    else $error("unmapped access without error");
  a_ctrl_back: assert property (pready && !pwrite && paddr == 12'h000 |->
    prdata == {24'h0, ctrl_r})
    else $error("control readback wrong");
  a_flag_sticky: assert property ($fell(ccpEventFlag) |->
    $past(acc && paddr == 12'h00c && pwdata[0]))
    else $error("flag cleared without software");
  a_conv_event: assert property (conversionStart |-> specialEvent)
    else $error("conversion start without event");
  a_event_pulse: assert property (specialEvent |=> !specialEvent)
    else $error("special event longer than one cycle");
  a_event_flag: assert property (specialEvent |-> ccpEventFlag && ctrl_r[3:0] == 4'hb)
    else $error("special event without flag or mode");
  a_off_quiet: assert property (quiet_r > 4'h2 && ctrl_r[3:0] == 4'h0 |->
    !outputA && !outputAEn && !outputBEn && !outputCEn && !outputDEn)
    else $error("outputs active while off");
  a_port_pins: assert property (quiet_r > 4'h2 && ctrl_r[3:2] != 2'b11 |->
    !outputBEn && !outputCEn && !outputDEn)
    else $error("bridge pin driven outside pwm");
  c_conv: cover property (conversionStart);
  c_capture: cover property ($rose(ccpEventFlag) && ctrl_r[3:2] == 2'b01);
  c_bridge: cover property (outputDEn && ctrl_r[7:6] == 2'b01);
endmodule // capture_compare_pwm_control_chk
bind capture_compare_pwm_control capture_compare_pwm_control_chk i_chk (.*);

/* File: tb/pin_driver.sv */
// external source on the capture pin
`timescale 1ns/10ps
module pin_driver (
  input wire ref_clk,
  output logic capturePin
);
  initial capturePin = 1'b0;
  // each level is held long enough for synchroniser and edge detect
  task drive(input bit lvl);
    @(posedge ref_clk);
    capturePin <= lvl;
    repeat (8) @(posedge ref_clk);
  endtask
  task pulse;
    drive(1'b1);
    drive(1'b0);
  endtask
endmodule // pin_driver

/* File: tb/test_capture_compare_pwm_control.sv */
// self-checking bench for the capture/compare/pwm control block
`timescale 1ns/10ps
module test_capture_compare_pwm_control;
  logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] timeBaseOne = 16'h0000;
  logic [7:0] timeBaseTwo = 8'h00;
  logic converterEnabled = 1'b1, capturePin, pready, pslverr, er, se;
  logic outputA, outputB, outputC, outputD, outputAEn, outputBEn, outputCEn, outputDEn;
  logic ccpEventFlag, specialEvent, conversionStart;
  int err_total = 0, check_count = 0;
  capture_compare_pwm_control i_capture_compare_pwm_control (.*);
  pin_driver i_pin_driver (.*);
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) timeBaseTwo <= timeBaseTwo + 8'h01;
  task chk(input [31:0] exp, input [31:0] got, input string nm);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  task apb(input bit w, input [11:0] a, input [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdv(input [11:0] a, input [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(exp, rd, nm);
  endtask
  task t_regs;
    rdv(12'h000, 32'h0, "ctrl reset");
    wr(12'h000, 32'h5a);
    rdv(12'h000, 32'h5a, "ctrl rw");
    rdv(12'h014, 32'h0, "unmapped data");
    chk(32'h1, {31'h0, er}, "unmapped err");
  endtask
  task t_capture;
    wr(12'h000, 32'h05);
    timeBaseOne <= 16'habcd;
    i_pin_driver.pulse;
    chk(32'h1, {31'h0, ccpEventFlag}, "capture flag");
    rdv(12'h004, 32'hcd, "capture low");
    rdv(12'h008, 32'hab, "capture high");
    timeBaseOne <= 16'h1234;
    i_pin_driver.pulse;
    rdv(12'h004, 32'h34, "overwrite low");
    rdv(12'h008, 32'h12, "overwrite high");
    wr(12'h00c, 32'h1);
    rdv(12'h00c, 32'h0, "flag cleared");
  endtask
  // two stray edges before the off write must not count afterwards
  task t_prescale(input [7:0] m, input int n);
    wr(12'h000, {24'h0, m});
    repeat (2) i_pin_driver.pulse;
    wr(12'h000, 32'h0);
    wr(12'h000, {24'h0, m});
    wr(12'h00c, 32'h1);
    repeat (n - 1) i_pin_driver.pulse;
    chk(32'h0, {31'h0, ccpEventFlag}, "early capture");
    i_pin_driver.pulse;
    chk(32'h1, {31'h0, ccpEventFlag}, "prescaled capture");
  endtask
  task t_falling;
    wr(12'h000, 32'h04);
    wr(12'h00c, 32'h1);
    i_pin_driver.drive(1'b1);
    chk(32'h0, {31'h0, ccpEventFlag}, "rise ignored");
    i_pin_driver.drive(1'b0);
    chk(32'h1, {31'h0, ccpEventFlag}, "fall capture");
  endtask
  // first special-event pass runs with the converter disabled
  task t_compare;
    logic [19:0] modes;
    logic [3:0] lvl;
    logic cs;
    modes = 20'hbb892; // reserved codes are never written
    lvl = 4'b0101;
    for (int i = 4; i >= 0; i--) begin
      timeBaseOne <= 16'h0000;
      converterEnabled <= (i != 4);
      wr(12'h000, {28'h0, modes[4*i+:4]});
      wr(12'h004, 32'h10);
      wr(12'h008, 32'h00);
      wr(12'h00c, 32'h1);
      timeBaseOne <= 16'h0010;
      se = 1'b0;
      cs = 1'b0;
      repeat (6) begin
        @(posedge ref_clk);
        se = se | (specialEvent === 1'b1);
        cs = cs | (conversionStart === 1'b1);
      end
      chk(32'h1, {31'h0, ccpEventFlag}, "match flag");
      chk({31'h0, i >= 3}, {31'h0, se}, "special event");
      chk({31'h0, i == 3}, {31'h0, cs}, "conversion start");
      if (i < 3) chk({31'h0, lvl[i]}, {31'h0, outputA}, "compare pin");
      chk(32'h0, {29'h0, outputBEn, outputCEn, outputDEn}, "port pins");
    end
  endtask
  task t_pwm;
    logic [15:0] en;
    en = 16'hf3f1;
    for (int s = 0; s < 4; s++) begin
      wr(12'h000, {24'h0, s[1:0], 6'h0c});
      repeat (3) @(posedge ref_clk);
      chk({28'h0, en[4*s+:4]}, {28'h0, outputDEn, outputCEn, outputBEn, outputAEn}, "steer");
    end
    // zero duty keeps the modulated output inactive, so pin levels are fixed
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h4c);
    repeat (3) @(posedge ref_clk);
    chk(32'h8, {28'h0, outputA, outputB, outputC, outputD}, "forward levels");
    wr(12'h000, 32'h4f);
    repeat (3) @(posedge ref_clk);
    chk(32'h7, {28'h0, outputA, outputB, outputC, outputD}, "forward low");
    wr(12'h000, 32'hcc);
    repeat (3) @(posedge ref_clk);
    chk(32'h2, {28'h0, outputA, outputB, outputC, outputD}, "reverse levels");
    wr(12'h000, 32'h0e);
    repeat (3) @(posedge ref_clk);
    chk(32'h8, {28'h0, outputA, outputB, outputC, outputD}, "single low");
    wr(12'h000, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk(32'h0, {27'h0, outputA, outputDEn, outputCEn, outputBEn, outputAEn}, "off");
  endtask
  task complete_run;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs;
    t_capture;
    t_prescale(8'h06, 4);
    t_prescale(8'h07, 16);
    t_falling;
    t_compare;
    t_pwm;
    complete_run;
  end
  initial begin
    #200000;
    err_total++;
    complete_run;
  end
endmodule // test_capture_compare_pwm_control
